/* File: rtl/dsl_pkg.sv */
// Constants shared by the dual converter serial load control
// Function
// [RULE1] Frame select low starts a write frame
// [RULE2] Capture one bit per falling edge, 24
// [RULE3] Early frame select rise discards partial write
// [RULE4] 24-bit shift register samples on falling edges
// [RULE5] Load pulse copies new inputs to outputs
// [RULE6] Load held low permanently also works
// [RULE7] Clear acts asynchronously on its falling edge; the code acts on clk_sys_i after a three-stage synchroniser
// [RULE8] Loads ignored while clear stays low
// [RULE9] Clear zeroes all input and output registers
// [RULE10] Clear mode ends at next write's 24th edge
// [RULE11] Clear during a frame aborts that write
// [RULE12] Host keeps serial clock at most 50 MHz
// [RULE13] Output registers hold 16-bit straight binary codes
// [RULE14] Nothing changes before the 24th falling edge
package dsl_pkg;
  localparam int FRAME_BITS = 24;
  localparam int DATA_BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] LAST_BIT_IDX = 5'h17;
  localparam logic [CNT_W-1:0] FRAME_DONE = 5'h18;
  localparam int DATA_LSB = 0;
  localparam int CHAN_SEL_BIT = 16;
  localparam int BOTH_SEL_BIT = 17;
  localparam logic [DATA_BITS-1:0] ZERO_SCALE = 16'h0000;
  localparam int SCLK_MAX_MHZ = 50;
  localparam int CLK_SYS_MHZ = 100;
  localparam logic CHAN_A = 1'b0;
  localparam logic CHAN_B = 1'b1;
endpackage

/* File: rtl/dsl_sync3.sv */
// Three-stage synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
module dsl_sync3
  import dsl_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Asynchronous input
  input wire logic async_i,
  // Filtered level and one-cycle edge pulses
  output logic level_o,
  output logic fall_o,
  output logic chg_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
    end
    else
    begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Change counts only when stages two and three agree
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      level_o <= RESET_VAL;
      fall_o <= 1'b0;
      chg_o <= 1'b0;
    end
    else
    begin
      fall_o <= 1'b0;
      chg_o <= 1'b0;
      if (s2_reg == s3_reg && s2_reg != level_o)
      begin
        level_o <= s2_reg;
        chg_o <= 1'b1;
        fall_o <= ~s2_reg;
      end
    end
  end
endmodule

/* File: rtl/dsl_serial_load.sv */
// Serial front end and register update logic of the dual converter
`timescale 1ns/10ps
module dsl_serial_load
  import dsl_pkg::*;
#(
  parameter int DATA_W = DATA_BITS
)
(
  // System clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Serial link from the host
  input wire logic sclk_i,
  input wire logic frame_sel_n_i,
  input wire logic sdata_i,
  // Control pins
  input wire logic load_outputs_n_i,
  input wire logic async_clear_n_i,
  // Converter codes and status
  output logic [DATA_W-1:0] channel_a_output_o,
  output logic [DATA_W-1:0] channel_b_output_o,
  output logic clear_mode_o
);

  // Link domain state, clocked by the falling serial clock
  logic [CNT_W-1:0] bit_cnt_reg;
  logic [FRAME_BITS-1:0] shift_reg;
  logic [FRAME_BITS-1:0] hold_reg;
  logic word_tgl_reg;

  // System domain state
  logic fs_level;
  logic fs_fall;
  logic clr_level;
  logic clr_fall;
  logic ld_level;
  logic tgl_chg;
  logic abort_reg;
  logic [DATA_W-1:0] in_a_reg;
  logic [DATA_W-1:0] in_b_reg;
  logic new_a_reg;
  logic new_b_reg;
  logic word_ok;
  logic load_ok;

  function automatic logic hits(input logic [FRAME_BITS-1:0] w, input logic chan);
    hits = w[BOTH_SEL_BIT] || (w[CHAN_SEL_BIT] == chan);
  endfunction

  // Frame select high holds the counter at zero, so an early rise aborts
  always_ff @(negedge sclk_i or posedge frame_sel_n_i or negedge rstn_i)
  begin
    if (!rstn_i)
      bit_cnt_reg <= CNT_ZERO;
    else if (frame_sel_n_i)
      bit_cnt_reg <= CNT_ZERO; // RULE3
    else if (bit_cnt_reg != FRAME_DONE)
      bit_cnt_reg <= bit_cnt_reg + CNT_ONE; // RULE1 RULE2
  end

  // Edges beyond the 24th are ignored until the next frame
  always_ff @(negedge sclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      shift_reg <= '0;
    else if (!frame_sel_n_i && bit_cnt_reg != FRAME_DONE)
      shift_reg <= {shift_reg[FRAME_BITS-2:0], sdata_i}; // RULE4
  end

  // Word is handed over only on the last edge of a frame
  always_ff @(negedge sclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      hold_reg <= '0;
      word_tgl_reg <= 1'b0;
    end
    else if (!frame_sel_n_i && bit_cnt_reg == LAST_BIT_IDX)
    begin
      hold_reg <= {shift_reg[FRAME_BITS-2:0], sdata_i}; // RULE14
      word_tgl_reg <= ~word_tgl_reg; // RULE2
    end
  end

  dsl_sync3 #(.RESET_VAL(1'b1)) u_fs_sync (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .async_i(frame_sel_n_i),
    .level_o(fs_level),
    .fall_o(fs_fall),
    .chg_o()
  );

  // Clear needs no serial clock edge to take effect
  dsl_sync3 #(.RESET_VAL(1'b1)) u_clr_sync (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .async_i(async_clear_n_i),
    .level_o(clr_level),
    .fall_o(clr_fall), // RULE7
    .chg_o()
  );

  dsl_sync3 #(.RESET_VAL(1'b1)) u_ld_sync (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .async_i(load_outputs_n_i),
    .level_o(ld_level),
    .fall_o(),
    .chg_o()
  );

  // Hold register is stable for many serial clocks after the toggle
  dsl_sync3 #(.RESET_VAL(1'b0)) u_tgl_sync (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .async_i(word_tgl_reg),
    .level_o(),
    .fall_o(),
    .chg_o(tgl_chg)
  );

  // Clear inside a frame poisons that frame; set wins over frame start
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      abort_reg <= 1'b0;
    else if (clr_fall && !fs_level)
      abort_reg <= 1'b1; // RULE11
    else if (fs_fall)
      abort_reg <= 1'b0;
  end

  always_comb
  begin
    word_ok = tgl_chg && !abort_reg && !clr_fall; // RULE11
    load_ok = !ld_level && clr_level && !clr_fall; // RULE6 RULE8
  end

  // Input registers
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      in_a_reg <= ZERO_SCALE;
      in_b_reg <= ZERO_SCALE;
    end
    else if (clr_fall)
    begin
      in_a_reg <= ZERO_SCALE; // RULE9
      in_b_reg <= ZERO_SCALE; // RULE9
    end
    else if (word_ok)
    begin
      if (hits(hold_reg, CHAN_A))
        in_a_reg <= hold_reg[DATA_LSB +: DATA_W]; // RULE13
      if (hits(hold_reg, CHAN_B))
        in_b_reg <= hold_reg[DATA_LSB +: DATA_W]; // RULE13
    end
  end

  // New data flags; a fresh word beats a load in the same cycle
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      new_a_reg <= 1'b0;
      new_b_reg <= 1'b0;
    end
    else if (clr_fall)
    begin
      new_a_reg <= 1'b0;
      new_b_reg <= 1'b0;
    end
    else
    begin
      if (word_ok && hits(hold_reg, CHAN_A))
        new_a_reg <= 1'b1;
      else if (load_ok)
        new_a_reg <= 1'b0;
      if (word_ok && hits(hold_reg, CHAN_B))
        new_b_reg <= 1'b1;
      else if (load_ok)
        new_b_reg <= 1'b0;
    end
  end

  // Level sensing serves both pulsed and tied-low load
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      channel_a_output_o <= ZERO_SCALE;
      channel_b_output_o <= ZERO_SCALE;
    end
    else if (clr_fall)
    begin
      channel_a_output_o <= ZERO_SCALE; // RULE9
      channel_b_output_o <= ZERO_SCALE; // RULE9
    end
    else if (load_ok)
    begin
      if (new_a_reg)
        channel_a_output_o <= in_a_reg; // RULE5
      if (new_b_reg)
        channel_b_output_o <= in_b_reg; // RULE5
    end
  end

  // Clear code mode
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      clear_mode_o <= 1'b0;
    else if (clr_fall)
      clear_mode_o <= 1'b1; // RULE10
    else if (word_ok)
      clear_mode_o <= 1'b0; // RULE10
  end

  // Checks in the system domain
  property p_zero_on_clear;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      clr_fall |=> channel_a_output_o == ZERO_SCALE && channel_b_output_o == ZERO_SCALE
        && in_a_reg == ZERO_SCALE && in_b_reg == ZERO_SCALE;
  endproperty
  a_zero_on_clear: assert property (p_zero_on_clear) else $error("clear did not zero registers"); // RULE9

  property p_clear_mode_set;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      clr_fall |=> clear_mode_o;
  endproperty
  a_clear_mode_set: assert property (p_clear_mode_set) else $error("clear mode not entered"); // RULE10

  property p_clear_mode_exit;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      word_ok |=> !clear_mode_o;
  endproperty
  a_clear_mode_exit: assert property (p_clear_mode_exit) else $error("clear mode kept after write"); // RULE10

  property p_no_load_in_clear;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      !clr_level && !clr_fall |=> $stable(channel_a_output_o) && $stable(channel_b_output_o);
  endproperty
  a_no_load_in_clear: assert property (p_no_load_in_clear) else $error("output moved while clear low"); // RULE8

  property p_abort_discards;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      tgl_chg && abort_reg && !clr_fall |=> $stable(in_a_reg) && $stable(in_b_reg);
  endproperty
  a_abort_discards: assert property (p_abort_discards) else $error("aborted word was stored"); // RULE11

  property p_load_copies;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      load_ok && new_a_reg |=> channel_a_output_o == $past(in_a_reg);
  endproperty
  a_load_copies: assert property (p_load_copies) else $error("load did not copy channel a"); // RULE5

  property p_held_low_updates;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      word_ok && hits(hold_reg, CHAN_B) ##1 (load_ok && !word_ok)
        |=> channel_b_output_o == $past(in_b_reg);
  endproperty
  a_held_low_updates: assert property (p_held_low_updates) else $error("tied load missed update"); // RULE6

  property p_word_stores;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      word_ok && hits(hold_reg, CHAN_A) |=> in_a_reg == $past(hold_reg[DATA_LSB +: DATA_W]);
  endproperty
  a_word_stores: assert property (p_word_stores) else $error("channel a input not written"); // RULE13

  property p_idle_cnt_zero;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      frame_sel_n_i |-> bit_cnt_reg == CNT_ZERO;
  endproperty
  a_idle_cnt_zero: assert property (p_idle_cnt_zero) else $error("counter runs outside frame"); // RULE1

  property p_abort_set;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      clr_fall && !fs_level |=> abort_reg;
  endproperty
  a_abort_set: assert property (p_abort_set) else $error("clear inside frame not flagged"); // RULE11

  property p_load_copies_b;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      load_ok && new_b_reg |=> channel_b_output_o == $past(in_b_reg);
  endproperty
  a_load_copies_b: assert property (p_load_copies_b) else $error("load did not copy channel b"); // RULE5

  property p_stale_not_loaded;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      load_ok && !new_a_reg |=> $stable(channel_a_output_o);
  endproperty
  a_stale_not_loaded: assert property (p_stale_not_loaded) else $error("load moved channel a without new data"); // RULE5

  property p_outputs_quiet;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      !clr_fall && !load_ok |=> $stable(channel_a_output_o) && $stable(channel_b_output_o);
  endproperty
  a_outputs_quiet: assert property (p_outputs_quiet) else $error("output moved without load or clear"); // RULE14

  property p_inputs_quiet;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      !clr_fall && !word_ok |=> $stable(in_a_reg) && $stable(in_b_reg);
  endproperty
  a_inputs_quiet: assert property (p_inputs_quiet) else $error("input register moved without a word"); // RULE14

  property p_word_stores_b;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      word_ok && hits(hold_reg, CHAN_B) |=> in_b_reg == $past(hold_reg[DATA_LSB +: DATA_W]);
  endproperty
  a_word_stores_b: assert property (p_word_stores_b) else $error("channel b input not written"); // RULE13

  property p_clear_mode_hold;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      clear_mode_o && !word_ok |=> clear_mode_o;
  endproperty
  a_clear_mode_hold: assert property (p_clear_mode_hold) else $error("clear mode left without a write"); // RULE10

  // Checks in the link domain
  // Rising edges see the count settled after each falling edge
  property p_cnt_bound;
    @(posedge sclk_i) disable iff (!rstn_i)
      !frame_sel_n_i |-> bit_cnt_reg != CNT_ZERO && bit_cnt_reg <= FRAME_DONE;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound) else $error("frame edge count out of range"); // RULE2

  // Seen at the next frame's first edge, since frame select rises in between
  property p_capture_last;
    @(negedge sclk_i) disable iff (!rstn_i)
      !frame_sel_n_i && bit_cnt_reg == LAST_BIT_IDX
        |=> hold_reg[FRAME_BITS-1:1] == $past(shift_reg[FRAME_BITS-2:0]) && hold_reg[0] == $past(sdata_i);
  endproperty
  a_capture_last: assert property (p_capture_last) else $error("final word not captured"); // RULE4

  property p_no_early_handover;
    @(negedge sclk_i) disable iff (!rstn_i || frame_sel_n_i)
      bit_cnt_reg != LAST_BIT_IDX |=> $stable(word_tgl_reg) && $stable(hold_reg);
  endproperty
  a_no_early_handover: assert property (p_no_early_handover) else $error("partial word handed over"); // RULE14

  c_word: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) word_ok);
  c_load: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) load_ok && new_a_reg);
  c_clear: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) clr_fall);
  c_abort: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) tgl_chg && abort_reg);
  c_tied_low: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) word_ok ##1 (load_ok && new_b_reg));
endmodule

/* File: dv/dsl_host_model.sv */
// Host serial port model driving the three-wire write link
`timescale 1ns/10ps
module dsl_host_model
(
  // Serial link towards the device
  output logic sclk_o,
  output logic frame_sel_n_o,
  output logic sdata_o
);
  initial
  begin
    sclk_o = 1'b1;
    frame_sel_n_o = 1'b1;
    sdata_o = 1'b0;
  end
  // Sends the first nbits of word MSB first; fewer than 24 makes an aborted frame
  task automatic send(input logic [23:0] word, input int nbits, input int half_ns);
    // Offset keeps link edges off the rising system clock edges
    #(3);
    frame_sel_n_o = 1'b0;
    for (int i = 23; i > 23 - nbits; i--)
    begin
      sdata_o = word[i];
      #(half_ns) sclk_o = 1'b0;
      #(half_ns) sclk_o = 1'b1;
    end
    frame_sel_n_o = 1'b1;
    // Released data line must not keep its last value
    sdata_o = ~sdata_o;
    #(half_ns);
  endtask
endmodule

/* File: dv/dual_dac_serial_load_control_test.sv */
// Self-checking testbench of the dual converter serial load control
`timescale 1ns/10ps
module dual_dac_serial_load_control_test
  import dsl_pkg::*;
;
  logic clk_sys_i;
  logic rstn_i;
  logic load_outputs_n_i;
  logic async_clear_n_i;
  logic sclk;
  logic frame_sel_n;
  logic sdata;
  logic [DATA_BITS-1:0] chan_a;
  logic [DATA_BITS-1:0] chan_b;
  logic clear_mode;
  int errors;
  int n_tests;
  int cycles;

  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  dsl_host_model i_host
  (
    .sclk_o(sclk),
    .frame_sel_n_o(frame_sel_n),
    .sdata_o(sdata)
  );

  dsl_serial_load i_dut
  (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .sclk_i(sclk),
    .frame_sel_n_i(frame_sel_n),
    .sdata_i(sdata),
    .load_outputs_n_i(load_outputs_n_i),
    .async_clear_n_i(async_clear_n_i),
    .channel_a_output_o(chan_a),
    .channel_b_output_o(chan_b),
    .clear_mode_o(clear_mode)
  );

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Long enough for the synchronisers and the update cycle
  task automatic settle();
    repeat (20) @(posedge clk_sys_i);
  endtask

  task automatic pulse_load();
    @(posedge clk_sys_i);
    load_outputs_n_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    load_outputs_n_i <= 1'b1;
    settle();
  endtask

  task automatic set_clear(input logic lvl);
    @(posedge clk_sys_i);
    async_clear_n_i <= lvl;
    settle();
  endtask

  // Word layout: bit 17 both channels, bit 16 channel B
  task automatic wr(input logic both, input logic chan, input logic [15:0] code);
    i_host.send({6'h00, both, chan, code}, 24, 32);
    settle();
  endtask

  task automatic t_hold_then_load();
    wr(1'b0, CHAN_A, 16'h1234);
    wr(1'b0, CHAN_B, 16'hFFFF);
    check(chan_a, 16'h0000);
    pulse_load();
    check(chan_a, 16'h1234);
    check(chan_b, 16'hFFFF);
  endtask

  task automatic t_abort();
    i_host.send({6'h02, 2'b10, 16'h5555}, 23, 32);
    settle();
    pulse_load();
    check(chan_a, 16'h1234);
    check(chan_b, 16'hFFFF);
  endtask

  task automatic t_tied_low();
    @(posedge clk_sys_i);
    load_outputs_n_i <= 1'b0;
    wr(1'b1, CHAN_A, 16'h8000);
    check(chan_a, 16'h8000);
    check(chan_b, 16'h8000);
    wr(1'b0, CHAN_A, 16'h7FFF);
    check(chan_a, 16'h7FFF);
    check(chan_b, 16'h8000);
    @(posedge clk_sys_i);
    load_outputs_n_i <= 1'b1;
  endtask

  task automatic t_clear();
    set_clear(1'b0);
    check(chan_a, 16'h0000);
    check(chan_b, 16'h0000);
    check({15'h0000, clear_mode}, 16'h0001);
    wr(1'b0, CHAN_A, 16'h4321);
    pulse_load();
    check(chan_a, 16'h0000);
    set_clear(1'b1);
    check(chan_a, 16'h0000);
    pulse_load();
    check(chan_a, 16'h4321);
  endtask

  task automatic t_clear_mid();
    fork
      i_host.send({6'h00, 2'b00, 16'hAAAA}, 24, 32);
      begin
        repeat (80) @(posedge clk_sys_i);
        async_clear_n_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        async_clear_n_i <= 1'b1;
      end
    join
    settle();
    check({15'h0000, clear_mode}, 16'h0001);
    pulse_load();
    check(chan_a, 16'h0000);
    wr(1'b0, CHAN_B, 16'h0101);
    check({15'h0000, clear_mode}, 16'h0000);
    pulse_load();
    check(chan_b, 16'h0101);
  endtask

  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      $display("ERROR at %0t: run did not finish", $time);
      stop_test();
    end
  end

  initial
  begin
    errors = 0;
    n_tests = 0;
    cycles = 0;
    rstn_i = 1'b0;
    load_outputs_n_i = 1'b1;
    async_clear_n_i = 1'b1;
    repeat (6) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    settle();
    check(chan_a, 16'h0000);
    t_hold_then_load();
    t_abort();
    t_tied_low();
    t_clear();
    t_clear_mid();
    stop_test();
  end
endmodule
